// File: rsip_regs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: one reference clock cycle per sys_clk cycle
// Notes:   included by the core and by the bench
`ifndef RSIP_REGS_SVH
`define RSIP_REGS_SVH
// ==========================================================================
// register offsets (byte addresses, one word each)
`define RSIP_OFS_FLAGS    8'h00
`define RSIP_OFS_CTRL     8'h04
`define RSIP_OFS_STATUS   8'h08
// ==========================================================================
// reset cause flag positions
`define RSIP_F_UNDERV     1
`define RSIP_F_MONITOR    2
`define RSIP_F_BADADDR    3
`define RSIP_F_BADOP      4
`define RSIP_F_WATCHDOG   5
`define RSIP_F_EXTLINE    6
`define RSIP_F_POWERON    7
`define RSIP_FLAGS_RST    8'h80
// ==========================================================================
// control fields
`define RSIP_C_HALTOK     0
`define RSIP_CTRL_RST     8'h00
// ==========================================================================
// timing, in reference clock cycles, then in sys_clk cycles
`define RSIP_REF_PER_SYS  1
`define RSIP_STAB_REF     4096
`define RSIP_PIN_REF      32
`define RSIP_HOLD_REF     32
`define RSIP_STAB_CYC     (`RSIP_STAB_REF / `RSIP_REF_PER_SYS)
`define RSIP_PIN_CYC      (`RSIP_PIN_REF / `RSIP_REF_PER_SYS)
`define RSIP_HOLD_CYC     (`RSIP_HOLD_REF / `RSIP_REF_PER_SYS)
// ==========================================================================
// vectors and stacking
`define RSIP_VEC_TRAP     16'hFFFC
`define RSIP_STACK_BYTES  5
`endif

// File: rsip_pkg.sv
// Purpose: types shared by the reset and interrupt unit
// Assumes: nothing
// Notes:   numbers live in rsip_regs.svh
package rsip_pkg;
  // ========================================================================
  // reset sequencer states
  typedef enum logic [2:0] {RS_RUN, RS_LOWV, RS_STAB, RS_PINLOW, RS_HOLD,
                            RS_EXTLOW} rsip_rst_state_t;
  // interrupt entry engine states
  typedef enum logic [1:0] {IE_IDLE, IE_PUSH, IE_VEC, IE_POP} rsip_ie_state_t;
  // ========================================================================
  // processor registers seen by stacking
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  x;
    logic [7:0]  a;
    logic [7:0]  ccr;
    logic [15:0] sp;
  } rsip_cpu_regs_t;
  // peripheral requests, already gated by their local enables
  typedef struct packed {
    logic extLine;
    logic lockChange;
    logic t1ch0;
    logic t1ch1;
    logic t1wrap;
    logic t2ch0;
    logic t2ch1;
    logic t2wrap;
    logic serialRxFull;
    logic serialOverflow;
    logic serialModeFault;
    logic serialTxEmpty;
    logic serialOverrun;
  } rsip_irq_src_t;
endpackage : rsip_pkg

// File: rsip_core.sv
// Purpose: reset sequencing, reset cause flags and interrupt entry
// Assumes: sys_clk is the oscillator reference clock; core events are
//          one-cycle pulses; stack memory answers reads one cycle later
// Notes:   arst_n is the power-on reset
// Operation
// - after undervoltage, clocks stay stopped 4096 cycles once supply recovers
// - reset line driven low while supply low and during stabilisation
// - reset line released 32 cycles after stabilisation ends
// - core starts reset vector fetch 64 cycles after stabilisation ends
// - undervoltage reset sets the undervoltage flag
// - illegal opcode causes internal reset and sets bad opcode flag
// - halt with permit bit clear counts as illegal opcode
// - opcode fetch from unmapped address resets and sets bad address flag
// - data accesses to unmapped addresses never cause a reset
// - flag register is read only and cleared by every read
// - at power up only the power-on flag is set
// - line sampled 32 cycles after release; low sets external flag
// - flags accumulate until software reads them
// - external, watchdog and monitor entry flags each set by own source
// - interrupts taken only at instruction boundaries
// - entry stacks processor registers; return restores them
// - entry sets global mask; latched interrupt cannot be pre-empted
// - at boundary with mask clear, highest priority pending is served
// - index high byte is not stacked on entry
// - vectors: reset FFFE, trap FFFC, external FFFA, then down by two
// - fixed priority, 0 highest, serial overrun lowest at 11
// - global mask masks everything except the software trap
// - internal resets drive line low 32 cycles then hold 32 more
`timescale 1ns/1ps
`include "rsip_regs.svh"
module rsip_core
  import rsip_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic           arst_n,
  input  wire logic           wb_cyc_i,
  input  wire logic           wb_stb_i,
  input  wire logic           wb_we_i,
  input  wire logic [7:0]     wb_adr_i,
  input  wire logic [3:0]     wb_sel_i,
  input  wire logic [31:0]    wb_dat_i,
  output logic      [31:0]    wb_dat_o,
  output logic                wb_ack_o,
  input  wire logic           supplyLow,
  input  wire logic           watchdogTimeout,
  input  wire logic           monitorEntry,
  input  wire logic           rstLineIn,
  output logic                rstLineOut,
  output logic                rstLineOe_n,
  output logic                clocksRun,
  output logic                cpuReset,
  input  wire logic           opcodeIllegal,
  input  wire logic           opcodeHalt,
  input  wire logic           fetchValid,
  input  wire logic           fetchUnmapped,
  input  wire logic           instrDone,
  input  wire logic           trapExec,
  input  wire logic           returnExec,
  input  wire logic           globalMask,
  input  wire rsip_irq_src_t  irqSrc,
  input  wire rsip_cpu_regs_t cpuRegs,
  output logic                intTake,
  output logic                setMask,
  output logic                vecLoad,
  output logic      [15:0]    vecAddr,
  output logic                stkWrEn,
  output logic                stkRdEn,
  output logic      [15:0]    stkAddr,
  output logic      [7:0]     stkWrData,
  input  wire logic [7:0]     stkRdData,
  output logic                restoreValid,
  output rsip_cpu_regs_t      restoreRegs
);
  // ========================================================================
  // register bus
  logic [7:0]  flags;
  logic [7:0]  ctrl;
  logic [7:0]  setBits;
  logic [7:0]  next_flags;
  logic [3:0]  pendIdx;
  rsip_rst_state_t rstState;
  rsip_ie_state_t  ieState;
  wire         busReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire         selFlags  = wb_adr_i == `RSIP_OFS_FLAGS;
  wire         selCtrl   = wb_adr_i == `RSIP_OFS_CTRL;
  wire         selStatus = wb_adr_i == `RSIP_OFS_STATUS;
  wire         flagsRead = busReq & ~wb_we_i & selFlags;
  wire         ctrlWrite = busReq & wb_we_i & selCtrl & wb_sel_i[0];
  wire  [31:0] rdMux     = selFlags  ? {24'h00_0000, flags} :
                           selCtrl   ? {24'h00_0000, ctrl} :
                           selStatus ? {23'h00_0000, ieState, pendIdx, rstState} :
                                       32'h0000_0000;
  // one wait state; unmapped reads return zero, unmapped writes are dropped
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl     <= `RSIP_CTRL_RST;
    end else begin
      wb_ack_o <= busReq;
      if (busReq && !wb_we_i) begin
        wb_dat_o <= rdMux;
      end
      if (ctrlWrite) begin
        ctrl <= wb_dat_i[7:0];
      end
    end
  end
  // ========================================================================
  // reset sources
  wire inRun      = rstState == RS_RUN;
  wire haltBad    = opcodeHalt & ~ctrl[`RSIP_C_HALTOK];
  wire badOp      = inRun & (opcodeIllegal | haltBad);
  // only fetches are checked; data accesses never reach this block
  wire badFetch   = inRun & fetchValid & fetchUnmapped;
  wire dogHit     = inRun & watchdogTimeout;
  wire monHit     = inRun & monitorEntry;
  wire intReset   = badOp | badFetch | dogHit | monHit;
  wire extLow     = inRun & ~rstLineIn;
  logic [12:0] cnt;
  wire holdEnd    = rstState == RS_HOLD && cnt == 13'(`RSIP_HOLD_CYC - 1);
  wire lateSample = holdEnd & ~rstLineIn;
  always_comb begin
    setBits = 8'h00;
    setBits[`RSIP_F_UNDERV]   = supplyLow;
    setBits[`RSIP_F_BADOP]    = badOp;
    setBits[`RSIP_F_BADADDR]  = badFetch;
    setBits[`RSIP_F_WATCHDOG] = dogHit;
    setBits[`RSIP_F_MONITOR]  = monHit;
    setBits[`RSIP_F_EXTLINE]  = extLow | lateSample;
  end
  // set wins over the read clear, so no cause is lost
  assign next_flags = (flagsRead ? 8'h00 : flags) | setBits;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags <= `RSIP_FLAGS_RST;
    end else begin
      flags <= next_flags;
    end
  end
  // ========================================================================
  // reset sequencer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstState <= RS_STAB;
      cnt      <= 13'h0000;
    end else if (supplyLow) begin
      rstState <= RS_LOWV;
      cnt      <= 13'h0000;
    end else begin
      cnt <= cnt + 13'h0001;
      unique case (rstState)
        RS_RUN: begin
          cnt <= 13'h0000;
          if (intReset) begin
            rstState <= RS_PINLOW;
          end else if (extLow) begin
            rstState <= RS_EXTLOW;
          end
        end
        RS_LOWV: begin
          rstState <= RS_STAB;
          cnt      <= 13'h0000;
        end
        RS_STAB: begin
          if (cnt == 13'(`RSIP_STAB_CYC - 1)) begin
            rstState <= RS_PINLOW;
            cnt      <= 13'h0000;
          end
        end
        RS_PINLOW: begin
          if (cnt == 13'(`RSIP_PIN_CYC - 1)) begin
            rstState <= RS_HOLD;
            cnt      <= 13'h0000;
          end
        end
        RS_HOLD: begin
          if (holdEnd) begin
            rstState <= RS_RUN;
          end
        end
        RS_EXTLOW: begin
          cnt <= 13'h0000;
          if (rstLineIn) begin
            rstState <= RS_HOLD;
          end
        end
      endcase
    end
  end
  // the line is open drain: only ever pulled low
  assign rstLineOut  = 1'b0;
  assign rstLineOe_n = ~(rstState == RS_LOWV || rstState == RS_STAB ||
                         rstState == RS_PINLOW);
  assign clocksRun   = ~(rstState == RS_LOWV || rstState == RS_STAB);
  assign cpuReset    = ~inRun;
  // ========================================================================
  // interrupt priority
  logic [11:1] req;
  assign req = {irqSrc.serialOverrun, irqSrc.serialTxEmpty,
                irqSrc.serialRxFull | irqSrc.serialOverflow |
                irqSrc.serialModeFault,
                irqSrc.t2wrap, irqSrc.t2ch1, irqSrc.t2ch0,
                irqSrc.t1wrap, irqSrc.t1ch1, irqSrc.t1ch0,
                irqSrc.lockChange, irqSrc.extLine};
  // lowest index wins; the loop runs downward so index 1 is written last
  always_comb begin
    pendIdx = 4'h0;
    for (int i = 11; i >= 1; i--) begin
      if (req[i]) begin
        pendIdx = 4'(i);
      end
    end
  end
  wire ieIdle   = ieState == IE_IDLE;
  wire boundary = inRun & ieIdle & instrDone;
  wire maskable = ~globalMask & (pendIdx != 4'h0);
  assign intTake = boundary & (trapExec | maskable);
  wire  [15:0] pickVec = trapExec ? `RSIP_VEC_TRAP :
                         16'(`RSIP_VEC_TRAP - {11'h000, pendIdx, 1'b0});
  // ========================================================================
  // stacking engine
  logic [2:0]  step;
  logic [15:0] spBase;
  rsip_cpu_regs_t saved;
  wire         popStart = inRun & ieIdle & returnExec;
  wire         lastStep = step == 3'(`RSIP_STACK_BYTES - 1);
  // high byte of the index register is absent from this order
  always_comb begin
    unique case (step)
      3'd0:    stkWrData = saved.pc[7:0];
      3'd1:    stkWrData = saved.pc[15:8];
      3'd2:    stkWrData = saved.x;
      3'd3:    stkWrData = saved.a;
      default: stkWrData = saved.ccr;
    endcase
  end
  assign stkWrEn = ieState == IE_PUSH;
  assign stkRdEn = ieState == IE_POP && step <= 3'(`RSIP_STACK_BYTES - 1);
  assign stkAddr = stkWrEn ? 16'(spBase - {13'h0000, step}) :
                             16'(spBase + 16'h0001 + {13'h0000, step});
  assign setMask = ieState == IE_VEC;
  assign vecLoad = ieState == IE_VEC;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ieState      <= IE_IDLE;
      step         <= 3'd0;
      spBase       <= 16'h0000;
      saved        <= '0;
      vecAddr      <= 16'hFFFE;
      restoreValid <= 1'b0;
      restoreRegs  <= '0;
    end else begin
      restoreValid <= 1'b0;
      step         <= step + 3'd1;
      unique case (ieState)
        IE_IDLE: begin
          step <= 3'd0;
          if (intTake) begin
            ieState <= IE_PUSH;
            saved   <= cpuRegs;
            spBase  <= cpuRegs.sp;
            vecAddr <= pickVec;
          end else if (popStart) begin
            ieState <= IE_POP;
            spBase  <= cpuRegs.sp;
          end
        end
        IE_PUSH: begin
          if (lastStep) begin
            ieState <= IE_VEC;
          end
        end
        IE_VEC: begin
          ieState <= IE_IDLE;
        end
        IE_POP: begin
          // read data lags its address by one cycle
          unique case (step)
            3'd1:    restoreRegs.ccr       <= stkRdData;
            3'd2:    restoreRegs.a         <= stkRdData;
            3'd3:    restoreRegs.x         <= stkRdData;
            3'd4:    restoreRegs.pc[15:8]  <= stkRdData;
            3'd5:    restoreRegs.pc[7:0]   <= stkRdData;
            default: restoreRegs.sp        <= 16'(spBase + 16'(`RSIP_STACK_BYTES));
          endcase
          if (step == 3'(`RSIP_STACK_BYTES)) begin
            ieState      <= IE_IDLE;
            restoreValid <= 1'b1;
          end
        end
      endcase
      if (!inRun) begin
        ieState <= IE_IDLE;
      end
    end
  end
  // ========================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [12:0] stabLen;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stabLen <= 13'h0000;
    end else begin
      stabLen <= (rstState == RS_STAB) ? stabLen + 13'h0001 : 13'h0000;
    end
  end
  sequence s_stabEnd;
    rstState == RS_STAB ##1 rstState == RS_PINLOW;
  endsequence
  sequence s_entry;
    intTake ##1 stkWrEn [*5];
  endsequence
  chk_stab_length: assert property ((rstState == RS_STAB) && !supplyLow
    |=> (rstState == RS_STAB) || stabLen == 13'(`RSIP_STAB_CYC))
    else $error("stabilisation delay wrong length");
  chk_line_low: assert property ((rstState == RS_LOWV || rstState == RS_STAB)
    |-> !rstLineOe_n && !clocksRun)
    else $error("line or clocks not held during undervoltage");
  chk_line_release: assert property (disable iff (!arst_n || supplyLow)
    s_stabEnd |-> ##31 !rstLineOe_n ##1 rstLineOe_n)
    else $error("reset line not released after 32 cycles");
  chk_cpu_start: assert property (disable iff (!arst_n || supplyLow)
    s_stabEnd |-> ##63 cpuReset ##1 !cpuReset)
    else $error("core not started after 64 cycles");
  chk_badop_reset: assert property (badOp && !supplyLow
    |=> flags[`RSIP_F_BADOP] && rstState == RS_PINLOW)
    else $error("illegal opcode did not reset");
  chk_read_clear: assert property (flagsRead && setBits == 8'h00
    |=> flags == 8'h00)
    else $error("flag read did not clear");
  chk_set_survives: assert property (flagsRead && setBits != 8'h00
    |=> (flags & $past(setBits)) == $past(setBits))
    else $error("event lost to read clear");
  chk_entry_order: assert property (s_entry |-> ##1 vecLoad && setMask)
    else $error("stacking sequence wrong");
  chk_no_preempt: assert property (intTake |-> ##1 (!intTake) [*6])
    else $error("entry pre-empted");
  chk_mask_gate: assert property (boundary && globalMask && !trapExec
    |-> !intTake)
    else $error("masked request taken");
  chk_trap_vector: assert property (intTake && trapExec
    |=> vecAddr == `RSIP_VEC_TRAP)
    else $error("trap vector wrong");
endmodule : rsip_core

// File: rsip_far_model.sv
// Purpose: far side of the unit: stack memory and the wired reset line
// Assumes: reset line has a pull-up; stack answers one cycle after a read
// Notes:   unread data lines toggle so stale bytes never look valid
`timescale 1ns/1ps
module rsip_far_model (
  input  wire logic        sys_clk,
  input  wire logic        stkWrEn,
  input  wire logic        stkRdEn,
  input  wire logic [15:0] stkAddr,
  input  wire logic [7:0]  stkWrData,
  input  wire logic        rstLineOut,
  input  wire logic        rstLineOe_n,
  input  wire logic        extPull,
  output logic      [7:0]  stkRdData,
  output logic             rstLineIn
);
  // ==========================================================================
  // stack memory, low address byte only
  logic [7:0] mem [0:255];
  initial stkRdData = 8'h00;
  always @(posedge sys_clk) begin
    if (stkWrEn) mem[stkAddr[7:0]] <= stkWrData;
    stkRdData <= stkRdEn ? mem[stkAddr[7:0]] : ~stkRdData;
  end
  // ==========================================================================
  // wired line: pull-up unless the unit or an outside device pulls low
  assign rstLineIn = (rstLineOe_n | rstLineOut) & !extPull;
endmodule : rsip_far_model

// File: tb_rsip_core.sv
// Purpose: self-checking bench for the reset and interrupt unit
// Assumes: one reference cycle per sys_clk cycle
// Notes:   random stimulus from a fixed seed, corner cases among it
`timescale 1ns/1ps
`include "rsip_regs.svh"
module tb_rsip_core
  import rsip_pkg::*;
;
  // ==========================================================================
  // stimulus and observed signals
  logic sys_clk = 1'b0, arst_n = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, rstLineOut, rstLineOe_n;
  logic [7:0] wbAdr = 8'h00, stkWrData, stkRdData;
  logic [31:0] wbDatI = 32'h0000_0000, wbDatO, q;
  logic supplyLow = 1'b0, watchdogTimeout = 1'b0, extPull = 1'b0, rstLineIn;
  logic [4:0] evt = 5'h00;
  logic instrDone = 1'b0, trapExec = 1'b0, returnExec = 1'b0, globalMask = 1'b0;
  logic clocksRun, cpuReset, intTake, setMask, vecLoad, stkWrEn, stkRdEn, restoreValid;
  logic [15:0] vecAddr, stkAddr, vecSeen;
  rsip_irq_src_t irqSrc = '0;
  rsip_cpu_regs_t cpuRegs = '0, restoreRegs, rstSeen;
  logic maskSeen;
  int failCount = 0, testsRun = 0, seed = 98, n;
  int takeCnt = 0, wrCnt = 0, rvCnt = 0;
  always #2.5 sys_clk = ~sys_clk;
  rsip_core rsip_core_inst (.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .supplyLow(supplyLow),
    .watchdogTimeout(watchdogTimeout), .monitorEntry(evt[0]), .rstLineIn(rstLineIn),
    .rstLineOut(rstLineOut), .rstLineOe_n(rstLineOe_n), .clocksRun(clocksRun),
    .cpuReset(cpuReset), .opcodeIllegal(evt[4]), .opcodeHalt(evt[3]),
    .fetchValid(evt[2]), .fetchUnmapped(evt[1]), .instrDone(instrDone),
    .trapExec(trapExec), .returnExec(returnExec), .globalMask(globalMask),
    .irqSrc(irqSrc), .cpuRegs(cpuRegs), .intTake(intTake), .setMask(setMask),
    .vecLoad(vecLoad), .vecAddr(vecAddr), .stkWrEn(stkWrEn), .stkRdEn(stkRdEn),
    .stkAddr(stkAddr), .stkWrData(stkWrData), .stkRdData(stkRdData),
    .restoreValid(restoreValid), .restoreRegs(restoreRegs));
  rsip_far_model rsip_far_model_inst (.sys_clk(sys_clk), .stkWrEn(stkWrEn),
    .stkRdEn(stkRdEn), .stkAddr(stkAddr), .stkWrData(stkWrData),
    .rstLineOut(rstLineOut), .rstLineOe_n(rstLineOe_n), .extPull(extPull),
    .stkRdData(stkRdData), .rstLineIn(rstLineIn));
  // ==========================================================================
  // monitor at the falling edge, where combinational pulses are settled
  always @(negedge sys_clk) begin
    if (intTake === 1'b1) takeCnt++;
    if (stkWrEn === 1'b1) wrCnt++;
    if (vecLoad === 1'b1) begin
      vecSeen = vecAddr;
      maskSeen = setMask;
    end
    if (restoreValid === 1'b1) begin
      rstSeen = restoreRegs;
      rvCnt++;
    end
  end
  // ==========================================================================
  // shared tasks
  task automatic giveVerdict;
    if (failCount == 0 && testsRun > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : giveVerdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      failCount++;
    end
  endtask : chk
  // one classic cycle; wd raises a watchdog pulse seen on the taking edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic wd, output logic [31:0] r);
    int k;
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    watchdogTimeout <= wd;
    k = 0;
    do begin
      @(posedge sys_clk);
      watchdogTimeout <= 1'b0;
      k++;
    end while (wbAck !== 1'b1 && k < 20);
    r = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    chk(k < 20, 1);
  endtask : wb
  // fire core events and count stopped-clock, line-low and reset cycles
  task automatic seq(input logic [4:0] v, input int eOff, input int eLow, input int eHi);
    int off, low, hi, k;
    off = 0;
    low = 0;
    hi = 0;
    k = 0;
    @(posedge sys_clk);
    evt <= v;
    supplyLow <= 1'b0;
    arst_n <= 1'b1;
    do begin
      @(posedge sys_clk);
      evt <= 5'h00;
      off += (clocksRun === 1'b0);
      low += (rstLineOe_n === 1'b0);
      hi += (cpuReset === 1'b1);
      k++;
    end while ((cpuReset !== 1'b0 || k < 2) && k < 9000);
    chk(off, eOff);
    chk(low, eLow);
    chk(hi, eHi);
  endtask : seq
  task automatic waitRun;
    n = 0;
    while (cpuReset !== 1'b0 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n < 300, 1);
  endtask : waitRun
  function automatic logic [15:0] expVec(input rsip_irq_src_t s, input logic t);
    logic [12:0] b;
    int idx;
    b = s;
    idx = 0;
    for (int i = 0; i < 13; i++)
      if (b[i]) idx = (i > 4) ? 13 - i : (i > 1) ? 9 : 11 - i;
    expVec = t ? `RSIP_VEC_TRAP : `RSIP_VEC_TRAP - 16'(2 * idx);
  endfunction : expVec
  // a boundary with requests, a second one while stacking, then stack, vector and return checks
  task automatic irq(input rsip_irq_src_t s, input logic m, input logic t, input logic d);
    rsip_cpu_regs_t r, rr;
    int t0, w0, v0;
    logic take;
    r = {$random(seed), $random(seed)};
    rr = ~r;
    rr.sp = r.sp - 16'd5;
    take = d & (t | (!m & (|s)));
    t0 = takeCnt;
    w0 = wrCnt;
    v0 = rvCnt;
    @(posedge sys_clk);
    irqSrc <= s;
    globalMask <= m;
    trapExec <= t & d;
    instrDone <= d;
    cpuRegs <= r;
    @(posedge sys_clk);
    instrDone <= 1'b0;
    trapExec <= 1'b0;
    repeat (2) @(posedge sys_clk);
    instrDone <= take;
    @(posedge sys_clk);
    instrDone <= 1'b0;
    irqSrc <= '0;
    repeat (6) @(posedge sys_clk);
    chk(takeCnt - t0, take);
    if (take) begin
      chk(vecSeen, expVec(s, t));
      chk(maskSeen, 1);
      chk(wrCnt - w0, 5);
      chk({rsip_far_model_inst.mem[8'(r.sp)], rsip_far_model_inst.mem[8'(r.sp - 16'd1)],
           rsip_far_model_inst.mem[8'(r.sp - 16'd2)]}, {r.pc[7:0], r.pc[15:8], r.x});
      chk({rsip_far_model_inst.mem[8'(r.sp - 16'd3)], rsip_far_model_inst.mem[8'(r.sp - 16'd4)]},
          {r.a, r.ccr});
      @(posedge sys_clk);
      cpuRegs <= rr;
      returnExec <= 1'b1;
      @(posedge sys_clk);
      returnExec <= 1'b0;
      repeat (10) @(posedge sys_clk);
      chk(rvCnt - v0, 1);
      chk({rstSeen.pc, rstSeen.x, rstSeen.a}, {r.pc, r.x, r.a});
      chk({rstSeen.ccr, rstSeen.sp}, {r.ccr, r.sp});
    end
  endtask : irq
  // ==========================================================================
  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    seq(5'h00, 4096, 4128, 4160);
    wb(1'b0, `RSIP_OFS_FLAGS, 32'h0, 1'b0, q);
    chk(q, `RSIP_FLAGS_RST);
    wb(1'b1, `RSIP_OFS_FLAGS, 32'hFF, 1'b0, q);
    wb(1'b0, `RSIP_OFS_FLAGS, 32'h0, 1'b0, q);
    chk(q, 32'h0000_0000);
    seq(5'h08, 0, 32, 64);
    seq(5'h10, 0, 32, 64);
    seq(5'h06, 0, 32, 64);
    seq(5'h01, 0, 32, 64);
    seq(5'h02, 0, 0, 0);
    wb(1'b0, `RSIP_OFS_FLAGS, 32'h0, 1'b1, q);
    chk(q, (1 << `RSIP_F_BADOP) | (1 << `RSIP_F_BADADDR) | (1 << `RSIP_F_MONITOR));
    waitRun;
    wb(1'b0, `RSIP_OFS_FLAGS, 32'h0, 1'b0, q);
    chk(q, 1 << `RSIP_F_WATCHDOG);
    wb(1'b1, `RSIP_OFS_CTRL, 32'h1, 1'b0, q);
    wb(1'b0, `RSIP_OFS_CTRL, 32'h0, 1'b0, q);
    chk(q, 32'h0000_0001);
    seq(5'h08, 0, 0, 0);
    wb(1'b1, 8'h0C, 32'hFF, 1'b0, q);
    wb(1'b0, 8'h0C, 32'h0, 1'b0, q);
    chk(q, 32'h0000_0000);
    supplyLow <= 1'b1;
    repeat (10) @(posedge sys_clk);
    // recovery is sampled one edge late, so one more stopped cycle is seen
    seq(5'h00, 4096 + 1, 4128 + 1, 4160 + 1);
    wb(1'b0, `RSIP_OFS_FLAGS, 32'h0, 1'b0, q);
    chk(q, 1 << `RSIP_F_UNDERV);
    extPull <= 1'b1;
    repeat (5) @(posedge sys_clk);
    extPull <= 1'b0;
    @(posedge sys_clk);
    waitRun;
    wb(1'b0, `RSIP_OFS_FLAGS, 32'h0, 1'b0, q);
    chk(q, 1 << `RSIP_F_EXTLINE);
    // line held low only up to the last hold cycle: just the late sample flags it
    @(posedge sys_clk);
    evt <= 5'h01;
    @(posedge sys_clk);
    evt <= 5'h00;
    extPull <= 1'b1;
    repeat (`RSIP_PIN_CYC + `RSIP_HOLD_CYC) @(posedge sys_clk);
    extPull <= 1'b0;
    waitRun;
    wb(1'b0, `RSIP_OFS_FLAGS, 32'h0, 1'b0, q);
    chk(q, (1 << `RSIP_F_MONITOR) | (1 << `RSIP_F_EXTLINE));
    // every source alone, then random mixes of mask, trap and boundary
    for (int i = 0; i < 13; i++) irq(rsip_irq_src_t'(13'h1 << i), 1'b0, 1'b0, 1'b1);
    irq('1, 1'b1, 1'b1, 1'b1);
    irq('1, 1'b1, 1'b0, 1'b1);
    irq('1, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 12; i++)
      irq(rsip_irq_src_t'($random(seed)), 1'($random(seed)), 1'($random(seed)),
          ($random(seed) & 3) != 0);
    giveVerdict;
  end
  initial begin
    #(5 * 40000);
    failCount++;
    giveVerdict;
  end
endmodule : tb_rsip_core
